// ==== design/cpu_ops_pkg.sv ====
package cpu_ops_pkg;

    // instruction word layout
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FILE_DEPTH = 128;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int FADDR_W = 7;
    localparam int DEST_BIT = 7;
    localparam int LIT_HI = 10;
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;

    // opcode masks and patterns
    localparam logic [13:0] MASK_CALL = 14'h3800;
    localparam logic [13:0] PAT_CALL = 14'h2000;
    localparam logic [13:0] MASK_EXACT = 14'h3fff;
    localparam logic [13:0] PAT_WDOG_RESTART = 14'h0064;
    localparam logic [13:0] MASK_CLR = 14'h3f80;
    localparam logic [13:0] PAT_FILE_CLEAR = 14'h0180;
    localparam logic [13:0] PAT_ACC_CLEAR = 14'h0100;
    localparam logic [13:0] MASK_FD = 14'h3f00;
    localparam logic [13:0] PAT_FILE_INVERT = 14'h0900;
    localparam logic [13:0] PAT_FILE_MINUS_ONE = 14'h0300;
    localparam logic [13:0] PAT_FILE_MINUS_ONE_SKIP = 14'h0b00;

    // register map, byte offsets on the 8-bit register port
    localparam logic [7:0] REG_ACC = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_UPPER_LATCH = 8'h02;
    localparam logic [7:0] REG_PC_LO = 8'h03;
    localparam logic [7:0] REG_PC_HI = 8'h04;
    localparam logic [7:0] REG_WDOG_COUNT = 8'h05;
    localparam logic [7:0] REG_STACK_PTR = 8'h06;
    localparam logic [7:0] REG_STACK_TOP_LO = 8'h07;
    localparam logic [7:0] REG_STACK_TOP_HI = 8'h08;
    localparam int FILE_WIN_BIT = 7;

    // status field positions
    localparam int ST_NULL = 2;
    localparam int ST_SLEEP = 3;
    localparam int ST_EXPIRED = 4;

    // reset values and watchdog timing
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] WDOG_PRE_LAST = 8'hff;
    localparam logic [7:0] WDOG_COUNT_LAST = 8'hff;

endpackage

// ==== design/cpu_call_clear_decrement_ops.sv ====
// Function
// - a call pushes the address of the following instruction, pc plus one, onto the stack.
// - a call loads its eleven-bit literal into pc bits 10 down to 0.
// - a call takes pc bits 12 and 11 from upper latch bits 4 and 3.
// - a call takes two instruction cycles and leaves the arithmetic flags alone.
// - watchdog restart clears the watchdog counter and its prescaler to zero.
// - watchdog restart sets the expired flag and the sleep-entered flag to one.
// - file clear writes zero to the addressed file register and sets the null flag.
// - file invert complements the register into accumulator (d=0) or register (d=1).
// - accumulator clear writes zero to the accumulator and sets the null flag.
// - file minus one decrements into accumulator (d=0) or register (d=1), null flag updated.
// - decrement-and-skip stores the decrement per d and leaves all flags alone.
// - a zero decrement-and-skip result discards the next instruction as an idle slot.
`timescale 1ns/1ps
`default_nettype none

module cpu_call_clear_decrement_ops
    import cpu_ops_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // instruction issue
    input wire logic instr_valid_i,
    input wire logic [INSTR_W-1:0] instr_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // core state
    output logic [PC_W-1:0] pc_o,
    output logic slot_o,
    output logic watchdog_timeout_o,
    output logic dog_expired_flag_o,
    output logic sleep_entered_flag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    // file and stack sit in the struct too, so one reset clears every flop except the expired and sleep-entered flags
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] acc;
        logic null_flag;
        logic dog_expired_flag;
        logic sleep_entered_flag;
        logic [DATA_W-1:0] upper_latch;
        logic [7:0] watchdog_counter;
        logic [7:0] watchdog_prescaler;
        logic [SP_W-1:0] sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [FILE_DEPTH-1:0][DATA_W-1:0] file;
        logic slot;
        logic timeout;
        logic [DATA_W-1:0] rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // one opcode compare, shared by every decode term
    function automatic logic op_match(
        input logic [INSTR_W-1:0] ins,
        input logic [INSTR_W-1:0] mask,
        input logic [INSTR_W-1:0] pat
    );
        return (ins & mask) == pat;
    endfunction

    // the upper half of the port map is the file register window
    function automatic logic in_file_window(
        input logic [7:0] addr
    );
        return addr[FILE_WIN_BIT];
    endfunction

    // row of the file register picked by a port address
    function automatic logic [FADDR_W-1:0] file_row(
        input logic [7:0] addr
    );
        return addr[FADDR_W-1:0];
    endfunction

    logic exec;
    logic is_call;
    logic is_restart;
    logic is_file_clear;
    logic is_acc_clear;
    logic is_invert;
    logic is_minus_one;
    logic is_minus_skip;
    logic dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic [SP_W-1:0] sp_top;
    logic [PC_W-1:0] pc_plus_one;

    // an instruction offered during an idle slot is dropped, never executed
    assign exec = instr_valid_i & ~state_reg.slot;
    assign is_call = op_match(instr_i, MASK_CALL, PAT_CALL);
    assign is_restart = op_match(instr_i, MASK_EXACT, PAT_WDOG_RESTART);
    assign is_file_clear = op_match(instr_i, MASK_CLR, PAT_FILE_CLEAR);
    assign is_acc_clear = op_match(instr_i, MASK_CLR, PAT_ACC_CLEAR);
    assign is_invert = op_match(instr_i, MASK_FD, PAT_FILE_INVERT);
    assign is_minus_one = op_match(instr_i, MASK_FD, PAT_FILE_MINUS_ONE);
    assign is_minus_skip = op_match(instr_i, MASK_FD, PAT_FILE_MINUS_ONE_SKIP);
    // operand fields are read whether or not the word decodes
    assign dest_file = instr_i[DEST_BIT];
    assign faddr = instr_i[FADDR_W-1:0];
    assign operand = state_reg.file[faddr];
    assign sp_top = SP_W'(state_reg.sp - 3'h1);

    // return address and the plain next pc are one and the same value
    assign pc_plus_one = PC_W'(state_reg.pc + 13'h0001);

    // invert or decrement result, shared by both destinations
    always_comb
    begin
        if (is_invert)
        begin
            result = ~operand;
        end
        else
        begin
            result = DATA_W'(operand - 8'h01);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_next = state_reg;
        state_next.timeout = 1'b0;
        state_next.rdata = 8'h00;
        state_next.slot = 1'b0;

        // register read, data shows one cycle later; unmapped reads zero
        if (rd_i)
        begin
            if (in_file_window(addr_i))
            begin
                state_next.rdata = state_reg.file[file_row(addr_i)];
            end
            else
            begin
                case (addr_i)
                    REG_ACC: state_next.rdata = state_reg.acc;
                    REG_STATUS:
                    begin
                        state_next.rdata[ST_NULL] = state_reg.null_flag;
                        state_next.rdata[ST_SLEEP] = state_reg.sleep_entered_flag;
                        state_next.rdata[ST_EXPIRED] = state_reg.dog_expired_flag;
                    end
                    REG_UPPER_LATCH: state_next.rdata = state_reg.upper_latch;
                    REG_PC_LO: state_next.rdata = state_reg.pc[7:0];
                    REG_PC_HI: state_next.rdata = DATA_W'(state_reg.pc[PC_W-1:8]);
                    REG_WDOG_COUNT: state_next.rdata = state_reg.watchdog_counter;
                    REG_STACK_PTR: state_next.rdata = DATA_W'(state_reg.sp);
                    // entry below sp; an empty stack shows the wrapped top slot
                    REG_STACK_TOP_LO: state_next.rdata = state_reg.stack[sp_top][7:0];
                    REG_STACK_TOP_HI:
                    begin
                        state_next.rdata = DATA_W'(state_reg.stack[sp_top][PC_W-1:8]);
                    end
                    default: state_next.rdata = 8'h00;
                endcase
            end
        end

        // software writes go first so a same-cycle instruction result wins
        if (wr_i)
        begin
            if (in_file_window(addr_i))
            begin
                state_next.file[file_row(addr_i)] = wdata_i;
            end
            else
            begin
                case (addr_i)
                    REG_ACC: state_next.acc = wdata_i;
                    REG_STATUS: state_next.null_flag = wdata_i[ST_NULL];
                    REG_UPPER_LATCH: state_next.upper_latch = wdata_i;
                    // read-only and unmapped places ignore the write
                    default: state_next.acc = state_next.acc;
                endcase
            end
        end

        // free-running watchdog: prescaler wrap advances the counter
        state_next.watchdog_prescaler = 8'(state_reg.watchdog_prescaler + 8'h01);
        if (state_reg.watchdog_prescaler == WDOG_PRE_LAST)
        begin
            state_next.watchdog_counter = 8'(state_reg.watchdog_counter + 8'h01);
            // counter wraps: one-cycle pulse, and the expired flag drops
            if (state_reg.watchdog_counter == WDOG_COUNT_LAST)
            begin
                state_next.timeout = 1'b1;
                state_next.dog_expired_flag = 1'b0;
            end
        end

        // instruction execution
        if (exec)
        begin
            // default step; a call or a taken skip overrides it below
            state_next.pc = pc_plus_one;
            if (is_call)
            begin
                // flags are not touched on this path
                state_next.stack[state_reg.sp] = pc_plus_one;
                state_next.sp = SP_W'(state_reg.sp + 3'h1);
                state_next.pc[LIT_HI:0] = instr_i[LIT_HI:0];
                state_next.pc[PC_W-1:LIT_HI+1] =
                    state_reg.upper_latch[LATCH_HI:LATCH_LO];
                state_next.slot = 1'b1;
            end
            else if (is_restart)
            begin
                // restart beats a same-cycle timeout, the count restarts anyway
                state_next.watchdog_counter = 8'h00;
                state_next.watchdog_prescaler = 8'h00;
                state_next.timeout = 1'b0;
                state_next.dog_expired_flag = 1'b1;
                // nothing in this block clears the sleep flag; only a sleep op would
                state_next.sleep_entered_flag = 1'b1;
            end
            else if (is_file_clear)
            begin
                state_next.file[faddr] = 8'h00;
                state_next.null_flag = 1'b1;
            end
            else if (is_acc_clear)
            begin
                state_next.acc = 8'h00;
                state_next.null_flag = 1'b1;
            end
            else if (is_invert || is_minus_one || is_minus_skip)
            begin
                if (dest_file)
                begin
                    state_next.file[faddr] = result;
                end
                else
                begin
                    state_next.acc = result;
                end
                if (!is_minus_skip)
                begin
                    state_next.null_flag = (result == 8'h00);
                end
                else if (result == 8'h00)
                begin
                    // jump over the discarded word, then burn one idle slot
                    state_next.pc = PC_W'(state_reg.pc + 13'h0002);
                    state_next.slot = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            // expired and sleep-entered flags come up set, the same as just after a restart
            state_reg <= '0;
            state_reg.pc <= PC_RESET;
            state_reg.dog_expired_flag <= 1'b1;
            state_reg.sleep_entered_flag <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    // status flags are levels, the timeout a one-cycle pulse
    assign rdata_o = state_reg.rdata;
    assign pc_o = state_reg.pc;
    assign slot_o = state_reg.slot;
    assign watchdog_timeout_o = state_reg.timeout;
    assign dog_expired_flag_o = state_reg.dog_expired_flag;
    assign sleep_entered_flag_o = state_reg.sleep_entered_flag;

endmodule

`default_nettype wire

// ==== verification/cpu_ops_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_ops_sva
    import cpu_ops_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // instruction issue
    input wire logic instr_valid_i,
    input wire logic [INSTR_W-1:0] instr_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    // core state
    input wire logic [PC_W-1:0] pc_o,
    input wire logic slot_o,
    input wire logic watchdog_timeout_o,
    input wire logic dog_expired_flag_o,
    input wire logic sleep_entered_flag_o
);
    // decode of the word taken at this edge; a word offered in a slot is not taken
    logic take;
    logic is_call;
    logic is_skip;
    logic is_restart;
    assign take = instr_valid_i && !slot_o;
    assign is_call = take && ((instr_i & MASK_CALL) == PAT_CALL);
    assign is_skip = take && ((instr_i & MASK_FD) == PAT_FILE_MINUS_ONE_SKIP);
    assign is_restart = take && (instr_i == PAT_WDOG_RESTART);

    ////////////////////////////////////////////////////////////////////////////////
    // one domain, so clocking and disable are given once
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    AST_CALL_LOW: assert property (is_call |=>
        pc_o[LIT_HI:0] == $past(instr_i[LIT_HI:0]))
        else $error("call target low bits wrong");
    AST_CALL_SLOT: assert property (is_call |=> slot_o ##1 !slot_o)
        else $error("call did not take exactly two cycles");
    AST_SLOT_HOLD: assert property (slot_o |=> pc_o == $past(pc_o))
        else $error("pc moved during an idle slot");
    AST_SLOT_CAUSE: assert property ($rose(slot_o) |-> $past(is_call || is_skip))
        else $error("idle slot without a call or skip");
    AST_SKIP_PC: assert property (is_skip |=>
        (slot_o && pc_o == $past(pc_o) + 13'd2) || (!slot_o && pc_o == $past(pc_o) + 13'd1))
        else $error("skip pc step wrong");
    AST_PLAIN_PC: assert property (take && !is_call && !is_skip
        |=> !slot_o && pc_o == $past(pc_o) + 13'd1)
        else $error("single-cycle op pc step wrong");
    AST_RESTART_FLAGS: assert property (is_restart |=>
        dog_expired_flag_o && sleep_entered_flag_o)
        else $error("restart left a status flag low");
    AST_RESTART_QUIET: assert property (is_restart |=> !watchdog_timeout_o [*8])
        else $error("timeout right after restart");

    // main scenarios reached
    cover property (is_call);
    cover property (is_skip ##1 slot_o);
    cover property (is_restart);
endmodule

bind cpu_call_clear_decrement_ops cpu_ops_sva i_sva (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pc_o(pc_o), .slot_o(slot_o), .watchdog_timeout_o(watchdog_timeout_o),
    .dog_expired_flag_o(dog_expired_flag_o), .sleep_entered_flag_o(sleep_entered_flag_o)
);

`default_nettype wire

// ==== verification/cpu_call_clear_decrement_ops_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_call_clear_decrement_ops_tb_top
    import cpu_ops_pkg::*;
;
    // design inputs, all given a value at time zero; outputs are left to the design
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [INSTR_W-1:0] instr_i = 14'h0000;
    logic [7:0] addr_i = 8'h00;
    logic [DATA_W-1:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [PC_W-1:0] pc_o;
    logic slot_o, watchdog_timeout_o, dog_expired_flag_o, sleep_entered_flag_o;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [PC_W-1:0] pc_exp = 13'h0000;
    logic [7:0] d;
    // word, file value, acc value, null preset, expected acc, file and null
    typedef struct {logic [13:0] w; logic [7:0] fv, av; logic pn;
        logic [7:0] ea, ef; logic en;} row_s;
    row_s rows[8] = '{
        '{14'h0185, 8'h3c, 8'h11, 1'b0, 8'h11, 8'h00, 1'b1},
        '{14'h0100, 8'h22, 8'h77, 1'b0, 8'h00, 8'h22, 1'b1},
        '{14'h0906, 8'h0f, 8'h11, 1'b1, 8'hf0, 8'h0f, 1'b0},
        '{14'h0987, 8'hff, 8'h11, 1'b0, 8'h11, 8'h00, 1'b1},
        '{14'h0308, 8'h01, 8'h33, 1'b0, 8'h00, 8'h01, 1'b1},
        '{14'h0389, 8'h00, 8'h33, 1'b1, 8'h33, 8'hff, 1'b0},
        '{14'h0b8a, 8'h05, 8'h33, 1'b1, 8'h33, 8'h04, 1'b1},
        '{14'h0b0b, 8'h06, 8'h33, 1'b0, 8'h05, 8'h06, 1'b0}};

    cpu_call_clear_decrement_ops i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pc_o(pc_o), .slot_o(slot_o),
        .watchdog_timeout_o(watchdog_timeout_o), .dog_expired_flag_o(dog_expired_flag_o),
        .sleep_entered_flag_o(sleep_entered_flag_o));

    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock; the full watchdog wrap makes the run about 66,200 cycles
    always #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 70000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus tasks: entered just after an edge, leave 1 ns after the taking edge
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic issue(input logic [13:0] w);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    // call, then offer a word inside its slot that must be dropped
    task automatic call_chk(input logic [7:0] lat, input logic [10:0] k);
        logic [PC_W-1:0] ret;
        ret = pc_exp + 13'd1;
        wr(REG_UPPER_LATCH, lat);
        wr(REG_STATUS, 8'h04);
        issue({3'b100, k});
        pc_exp = {lat[LATCH_HI:LATCH_LO], k};
        chk(pc_o, pc_exp);
        chk(slot_o, 1'b1);
        issue(PAT_ACC_CLEAR);
        chk(pc_o, pc_exp);
        rd(REG_STACK_TOP_LO, d);
        chk(d, ret[7:0]);
        rd(REG_STACK_TOP_HI, d);
        chk(d, {3'b000, ret[12:8]});
        rd(REG_STATUS, d);
        chk(d[ST_NULL], 1'b1);
        rd(REG_ACC, d);
        chk(d, 8'h05);
        $display("call test done");
    endtask
    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, table rows, then the awkward cases
    initial
    begin
        repeat (5) @(posedge mclk_i);
        #1;
        chk({pc_o, slot_o, dog_expired_flag_o, sleep_entered_flag_o}, 16'h0003);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        foreach (rows[i])
        begin
            wr({1'b1, rows[i].w[6:0]}, rows[i].fv);
            wr(REG_ACC, rows[i].av);
            wr(REG_STATUS, {5'b00000, rows[i].pn, 2'b00});
            issue(rows[i].w);
            pc_exp = pc_exp + 13'd1;
            chk(pc_o, pc_exp);
            rd(REG_ACC, d);
            chk(d, rows[i].ea);
            rd({1'b1, rows[i].w[6:0]}, d);
            chk(d, rows[i].ef);
            rd(REG_STATUS, d);
            chk(d[ST_NULL], rows[i].en);
            $display("row %0d done", i);
        end
        // upper latch bits other than 4:3 must not leak into the pc
        call_chk(8'h18, 11'h5a5);
        call_chk(8'he7, 11'h7ff);
        // skip on a zero result; the dropped invert would have left 8'hfe in acc
        wr(8'h8c, 8'h01);
        issue(14'h0b0c);
        pc_exp = pc_exp + 13'd2;
        chk({pc_o, slot_o}, {pc_exp, 1'b1});
        issue(14'h090c);
        chk(pc_o, pc_exp);
        rd(REG_ACC, d);
        chk(d, 8'h00);
        $display("skip test done");
        // let the watchdog advance past one prescaler period, then restart it
        repeat (600) @(posedge mclk_i);
        #1;
        rd(REG_WDOG_COUNT, d);
        chk(d != 8'h00, 1'b1);
        issue(PAT_WDOG_RESTART);
        pc_exp = pc_exp + 13'd1;
        chk({dog_expired_flag_o, sleep_entered_flag_o}, 2'b11);
        rd(REG_WDOG_COUNT, d);
        chk(d, 8'h00);
        // unmapped read and a write to a read-only place
        rd(8'h10, d);
        chk(d, 8'h00);
        wr(REG_PC_LO, 8'hff);
        chk(pc_o, pc_exp);
        $display("restart and access test done");
        // the wrap falls 65536 edges after the restart; the three bus
        // accesses above used three of them, and a stale prescaler would move it
        repeat (65532) @(posedge mclk_i);
        #1;
        chk({watchdog_timeout_o, dog_expired_flag_o}, 2'b01);
        @(posedge mclk_i);
        #1;
        chk({watchdog_timeout_o, dog_expired_flag_o}, 2'b10);
        @(posedge mclk_i);
        #1;
        chk({watchdog_timeout_o, dog_expired_flag_o}, 2'b00);
        // a restart after expiry must raise the expired flag again
        issue(PAT_WDOG_RESTART);
        pc_exp = pc_exp + 13'd1;
        chk({dog_expired_flag_o, sleep_entered_flag_o}, 2'b11);
        $display("watchdog expiry test done");
        // second reset in mid-run, then release and check the first edge
        reset_n_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk({pc_o, slot_o, dog_expired_flag_o, sleep_entered_flag_o}, 16'h0003);
        chk({rdata_o, watchdog_timeout_o}, 9'h000);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        chk(pc_o, 13'h0000);
        rd(REG_STACK_PTR, d);
        chk(d, 8'h00);
        $display("reset test done");
        print_verdict();
    end
endmodule

`default_nettype wire
